// ### hw/dual_timer_map.vh
// Register map, field codes and timing constants for the dual timers
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH

// Register word addresses
`define ADDR_IRQ_C        6'h02
`define ADDR_IRQ_D        6'h03
`define ADDR_C_MODE_ONE   6'h0d
`define ADDR_C_LOW        6'h0e
`define ADDR_C_HIGH       6'h0f
`define ADDR_D_MODE_ONE   6'h10
`define ADDR_D_LOW        6'h11
`define ADDR_D_HIGH       6'h12
`define ADDR_C_OUT_MODE   6'h14
`define ADDR_D_OUT_MODE   6'h15
`define ADDR_WATCHDOG     6'h20
`define ADDR_CAPTURE      6'h21
`define ADDR_PORT_SEL_C   6'h25
`define ADDR_EDGE_SEL     6'h27

// Bit positions
`define BIT_IRQ_C         2
`define BIT_IRQ_D         0
`define BIT_WD_EN         1
`define BIT_CAP_STATUS    0
`define BIT_CAP_ERROR     1
`define BIT_EVENT_PIN_EN  0
`define BIT_MODE_RELOAD   3
`define BIT_CAPTURE_MODE  3

// Reset values and counter top
`define NIBBLE_RESET      4'h0
`define BYTE_RESET        8'h00
`define PRESC_RESET       11'h000
`define COUNT_TOP         8'hff

// Output mode codes (low three bits)
`define OUT_PORT          3'h0
`define OUT_TOGGLE        3'h1
`define OUT_LOW           3'h2
`define OUT_HIGH          3'h3
`define OUT_PWM           3'h4

// Clock source codes (low three bits of mode one)
`define CLK_DIV1024       3'h0
`define CLK_DIV512        3'h1
`define CLK_DIV256        3'h2
`define CLK_DIV128        3'h3
`define CLK_DIV32         3'h4
`define CLK_DIV8          3'h5
`define CLK_DIV4          3'h6
`define CLK_EXT           3'h7

// Prescaler tap masks: a tick fires when the masked bits are all ones
`define TAP_1024          11'h3ff
`define TAP_512           11'h1ff
`define TAP_256           11'h0ff
`define TAP_128           11'h07f
`define TAP_32            11'h01f
`define TAP_8             11'h007
`define TAP_4             11'h003
`define TAP_2             11'h001

// Edge select codes
`define EDGE_NONE         2'h0
`define EDGE_FALL         2'h1
`define EDGE_RISE         2'h2
`define EDGE_BOTH         2'h3

// Mode-one write delay in instruction cycles (one cycle is one clock)
`define MODE_DELAY_CYC    2'h2
`define DELAY_ONE         2'h1
`define DELAY_ZERO        2'h0

`endif

// ### hw/dual_timers.v
// Two 8-bit multifunction timers with prescaler and nibble register port
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "dual_timer_map.vh"

// One timer channel: counter, mode registers, output pin and capture
module timer_channel #(
  parameter HAS_CAPTURE = 0
) (
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // Shared timing
  input  wire [10:0] presc,
  input  wire        ev_edge,
  input  wire        pin_en,
  // Register writes and the high nibble read strobe
  input  wire [3:0]  wdata,
  input  wire        wr_mode,
  input  wire        wr_low,
  input  wire        wr_high,
  input  wire        wr_out_mode,
  input  wire        rd_high,
  // State out
  output wire [3:0]  high_val,
  output wire [3:0]  low_val,
  output wire [3:0]  out_mode,
  output wire        pin_out,
  output wire        pin_sel,
  output wire        ovf,
  output wire        trig
);

  reg  [3:0] mode_eff_reg;
  reg  [3:0] mode_pend_reg;
  reg  [1:0] mode_wait_reg;
  reg  [3:0] load_low_reg;
  reg  [3:0] load_high_reg;
  reg  [7:0] count_reg;
  reg  [7:0] capture_reg;
  reg  [3:0] low_latch_reg;
  reg  [3:0] out_mode_reg;
  reg        pin_reg;
  reg        pin_sel_reg;
  reg        tap_hit;
  wire       tick;
  wire       capture_on;
  wire       enter_capture;
  wire [7:0] load_val;

  assign load_val = {load_high_reg, load_low_reg};
  assign capture_on = (HAS_CAPTURE != 0) &&
                      out_mode_reg[`BIT_CAPTURE_MODE];
  assign enter_capture = (HAS_CAPTURE != 0) && wr_out_mode &&
                         wdata[`BIT_CAPTURE_MODE] && !capture_on;

  // Prescaler tap per clock source; one tick each time the tap wraps
  always @* begin
    case (mode_eff_reg[2:0])
      `CLK_DIV1024: tap_hit = &(presc | ~`TAP_1024);
      `CLK_DIV512:  tap_hit = &(presc | ~`TAP_512);
      `CLK_DIV256:  tap_hit = &(presc | ~`TAP_256);
      `CLK_DIV128:  tap_hit = &(presc | ~`TAP_128);
      `CLK_DIV32:   tap_hit = &(presc | ~`TAP_32);
      `CLK_DIV8:    tap_hit = &(presc | ~`TAP_8);
      `CLK_DIV4:    tap_hit = &(presc | ~`TAP_4);
      default:      tap_hit = &(presc | ~`TAP_2);
    endcase
  end

  // External source only exists on the capture-capable channel
  assign tick = (HAS_CAPTURE != 0 && mode_eff_reg[2:0] == `CLK_EXT) ?
                (ev_edge && pin_en && !capture_on) :
                tap_hit;
  assign trig = capture_on && ev_edge && pin_en;
  assign ovf = tick && !trig && (count_reg == `COUNT_TOP);

  // Mode one is write-only and takes effect two cycles after a write
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_eff_reg  <= `NIBBLE_RESET;
      mode_pend_reg <= `NIBBLE_RESET;
      mode_wait_reg <= `DELAY_ZERO;
    end else if (wr_mode) begin
      mode_pend_reg <= wdata;
      mode_wait_reg <= `MODE_DELAY_CYC;
    end else if (mode_wait_reg != `DELAY_ZERO) begin
      mode_wait_reg <= mode_wait_reg - `DELAY_ONE;
      if (mode_wait_reg == `DELAY_ONE)
        mode_eff_reg <= mode_pend_reg;
    end
  end

  // Start value nibbles; the high nibble write is what loads the count
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      load_low_reg  <= `NIBBLE_RESET;
      load_high_reg <= `NIBBLE_RESET;
    end else begin
      if (wr_low)
        load_low_reg <= wdata;
      if (wr_high)
        load_high_reg <= wdata;
    end
  end

  // Counter: software load beats capture entry beats trigger beats tick
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg   <= `BYTE_RESET;
      capture_reg <= `BYTE_RESET;
    end else if (wr_high) begin
      count_reg <= {wdata, load_low_reg};
    end else if (enter_capture) begin
      count_reg <= `BYTE_RESET;
    end else if (trig) begin
      capture_reg <= count_reg;
      count_reg   <= `BYTE_RESET;
    end else if (tick) begin
      if (ovf)
        count_reg <= mode_eff_reg[`BIT_MODE_RELOAD] ?
                     load_val : `BYTE_RESET;
      else
        count_reg <= count_reg + 8'h01;
    end
  end

  // Reading the high nibble freezes the low nibble for a coherent byte
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      low_latch_reg <= `NIBBLE_RESET;
    else if (rd_high)
      low_latch_reg <= count_reg[3:0];
  end

  // A capture holds the whole byte, so either nibble order works
  assign high_val = capture_on ? capture_reg[7:4] : count_reg[7:4];
  assign low_val  = capture_on ? capture_reg[3:0] : low_latch_reg;

  // Output mode register; the narrow channel never holds the capture bit
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      out_mode_reg <= `NIBBLE_RESET;
    else if (wr_out_mode)
      out_mode_reg <= (HAS_CAPTURE != 0) ? wdata :
                      {1'b0, wdata[2:0]};
  end

  // Pin function: any output mode but port claims the pin, capture releases it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      pin_sel_reg <= 1'b0;
    else
      pin_sel_reg <= (out_mode[2:0] != `OUT_PORT) &&
                     !(HAS_CAPTURE != 0 &&
                       out_mode[`BIT_CAPTURE_MODE]);
  end

  // Output level; force modes assume software chose them sensibly
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_reg <= 1'b0;
    end else if (tick && !capture_on) begin
      case (out_mode_reg[2:0])
        `OUT_TOGGLE: if (ovf) pin_reg <= ~pin_reg;
        `OUT_LOW:    if (ovf) pin_reg <= 1'b0;
        `OUT_HIGH:   if (ovf) pin_reg <= 1'b1;
        `OUT_PWM: begin
          // Reload: one high tick per period; free: high from start value
          if (mode_eff_reg[`BIT_MODE_RELOAD])
            pin_reg <= ovf;
          else if (ovf)
            pin_reg <= 1'b0;
          else if (count_reg == load_val)
            pin_reg <= 1'b1;
        end
        default: pin_reg <= pin_reg;
      endcase
    end
  end

  assign out_mode = out_mode_reg;
  assign pin_out  = pin_reg;
  assign pin_sel  = pin_sel_reg;

endmodule // timer_channel

// Top: prescaler, register port, flags and the two channels
module dual_timers (
  // Clock and reset
  input  wire       clk,
  input  wire       arst_n,
  // Register port
  input  wire [5:0] addr,
  input  wire [3:0] wdata,
  input  wire       wr_en,
  input  wire       rd_en,
  output wire [3:0] rdata,
  // External pins
  input  wire       event_trigger_pin,
  output wire       first_timer_output_pin,
  output wire       first_timer_pin_sel,
  output wire       second_timer_output_pin,
  output wire       second_timer_pin_sel,
  // Status
  output wire       first_timer_irq_flag,
  output wire       second_timer_irq_flag,
  output wire       watchdog_reset
);

  reg  [10:0] presc_reg;
  reg  [3:0]  rdata_reg;
  reg  [3:0]  rdata_next;
  reg         ev_prev_reg;
  reg         irq_c_reg;
  reg         irq_d_reg;
  reg         wd_en_reg;
  reg         wd_reset_reg;
  reg         cap_status_reg;
  reg         cap_error_reg;
  reg         pin_en_reg;
  reg  [1:0]  edge_sel_reg;
  reg         ev_edge;
  wire [7:0]  high_val;
  wire [7:0]  low_val;
  wire [7:0]  out_mode;
  wire [1:0]  pin_out;
  wire [1:0]  pin_sel;
  wire [1:0]  ovf;
  wire [1:0]  trig;
  wire [1:0]  wr_mode;
  wire [1:0]  wr_low;
  wire [1:0]  wr_high;
  wire [1:0]  wr_out_mode;
  wire [1:0]  rd_high;

  // Free-running prescaler shared by both timers
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      presc_reg <= `PRESC_RESET;
    else
      presc_reg <= presc_reg + 11'h001;
  end

  // Pin is synchronous; one stage of history gives the edges
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      ev_prev_reg <= 1'b0;
    else
      ev_prev_reg <= event_trigger_pin;
  end

  always @* begin
    case (edge_sel_reg)
      `EDGE_FALL: ev_edge = ev_prev_reg && !event_trigger_pin;
      `EDGE_RISE: ev_edge = !ev_prev_reg && event_trigger_pin;
      `EDGE_BOTH: ev_edge = ev_prev_reg ^ event_trigger_pin;
      default:    ev_edge = 1'b0;
    endcase
  end

  // Per-channel strobe decode
  assign wr_mode = {wr_en && addr == `ADDR_D_MODE_ONE,
                    wr_en && addr == `ADDR_C_MODE_ONE};
  assign wr_low = {wr_en && addr == `ADDR_D_LOW,
                   wr_en && addr == `ADDR_C_LOW};
  assign wr_high = {wr_en && addr == `ADDR_D_HIGH,
                    wr_en && addr == `ADDR_C_HIGH};
  assign wr_out_mode = {wr_en && addr == `ADDR_D_OUT_MODE,
                        wr_en && addr == `ADDR_C_OUT_MODE};
  assign rd_high = {rd_en && addr == `ADDR_D_HIGH,
                    rd_en && addr == `ADDR_C_HIGH};

  // Channel 0 is the watchdog-capable timer, channel 1 has capture
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_chan
      timer_channel #(
        .HAS_CAPTURE (i)
      ) u_chan (
        .clk         (clk),
        .arst_n      (arst_n),
        .presc       (presc_reg),
        .ev_edge     (ev_edge),
        .pin_en      (pin_en_reg),
        .wdata       (wdata),
        .wr_mode     (wr_mode[i]),
        .wr_low      (wr_low[i]),
        .wr_high     (wr_high[i]),
        .wr_out_mode (wr_out_mode[i]),
        .rd_high     (rd_high[i]),
        .high_val    (high_val[i*4 +: 4]),
        .low_val     (low_val[i*4 +: 4]),
        .out_mode    (out_mode[i*4 +: 4]),
        .pin_out     (pin_out[i]),
        .pin_sel     (pin_sel[i]),
        .ovf         (ovf[i]),
        .trig        (trig[i])
      );
    end
  endgenerate

  // Flags: a hardware set in the same cycle as a clear wins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_c_reg      <= 1'b0;
      irq_d_reg      <= 1'b0;
      cap_status_reg <= 1'b0;
      cap_error_reg  <= 1'b0;
    end else begin
      irq_c_reg <= ovf[0] || (irq_c_reg && !(wr_en &&
                   addr == `ADDR_IRQ_C && !wdata[`BIT_IRQ_C]));
      irq_d_reg <= ovf[1] || trig[1] || (irq_d_reg && !(wr_en &&
                   addr == `ADDR_IRQ_D && !wdata[`BIT_IRQ_D]));
      cap_status_reg <= trig[1] || (cap_status_reg && !(wr_en &&
                        addr == `ADDR_CAPTURE &&
                        !wdata[`BIT_CAP_STATUS]));
      cap_error_reg <= (cap_status_reg && (trig[1] || ovf[1])) ||
                       (cap_error_reg && !(wr_en &&
                        addr == `ADDR_CAPTURE &&
                        !wdata[`BIT_CAP_ERROR]));
    end
  end

  // Plain control bits
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_en_reg    <= 1'b0;
      pin_en_reg   <= 1'b0;
      edge_sel_reg <= `EDGE_NONE;
    end else if (wr_en) begin
      if (addr == `ADDR_WATCHDOG)
        wd_en_reg <= wdata[`BIT_WD_EN];
      if (addr == `ADDR_PORT_SEL_C)
        pin_en_reg <= wdata[`BIT_EVENT_PIN_EN];
      if (addr == `ADDR_EDGE_SEL)
        edge_sel_reg <= wdata[1:0];
    end
  end

  // Watchdog bite: one-cycle request to the chip reset controller
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      wd_reset_reg <= 1'b0;
    else
      wd_reset_reg <= wd_en_reg && ovf[0];
  end

  // Read mux; write-only and unmapped words read as zero
  always @* begin
    rdata_next = `NIBBLE_RESET;
    case (addr)
      `ADDR_IRQ_C:      rdata_next[`BIT_IRQ_C] = irq_c_reg;
      `ADDR_IRQ_D:      rdata_next[`BIT_IRQ_D] = irq_d_reg;
      `ADDR_C_LOW:      rdata_next = low_val[3:0];
      `ADDR_C_HIGH:     rdata_next = high_val[3:0];
      `ADDR_D_LOW:      rdata_next = low_val[7:4];
      `ADDR_D_HIGH:     rdata_next = high_val[7:4];
      `ADDR_C_OUT_MODE: rdata_next = out_mode[3:0];
      `ADDR_D_OUT_MODE: rdata_next = out_mode[7:4];
      `ADDR_WATCHDOG:   rdata_next[`BIT_WD_EN] = wd_en_reg;
      `ADDR_CAPTURE: begin
        rdata_next[`BIT_CAP_STATUS] = cap_status_reg;
        rdata_next[`BIT_CAP_ERROR]  = cap_error_reg;
      end
      default:          rdata_next = `NIBBLE_RESET;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      rdata_reg <= `NIBBLE_RESET;
    else if (rd_en)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= `NIBBLE_RESET;
  end

  assign rdata                   = rdata_reg;
  assign first_timer_output_pin  = pin_out[0];
  assign first_timer_pin_sel     = pin_sel[0];
  assign second_timer_output_pin = pin_out[1];
  assign second_timer_pin_sel    = pin_sel[1];
  assign first_timer_irq_flag    = irq_c_reg;
  assign second_timer_irq_flag   = irq_d_reg;
  assign watchdog_reset          = wd_reset_reg;

endmodule // dual_timers

// ### tb/dual_timers_chk.sv
// Port assertions for the dual timers
`timescale 1ns/1ps
`include "dual_timer_map.vh"

module dual_timers_chk (
  // Clock and reset
  input wire       clk,
  input wire       arst_n,
  // Register port
  input wire [5:0] addr,
  input wire       wr_en,
  input wire       rd_en,
  input wire [3:0] rdata,
  // Pins and flags
  input wire       first_timer_output_pin,
  input wire       first_timer_pin_sel,
  input wire       second_timer_output_pin,
  input wire       second_timer_pin_sel,
  input wire       first_timer_irq_flag,
  input wire       second_timer_irq_flag,
  input wire       watchdog_reset
);
  // Writes that may move a select or clear a flag
  wire c_out_wr = wr_en && (addr == `ADDR_C_OUT_MODE);
  wire d_out_wr = wr_en && (addr == `ADDR_D_OUT_MODE);
  wire c_irq_wr = wr_en && (addr == `ADDR_IRQ_C);
  wire d_irq_wr = wr_en && (addr == `ADDR_IRQ_D);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Read data only in the answer cycle
  property p_rd_idle;
    !$past(rd_en) |-> rdata == 4'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("rdata outside answer cycle");

  // Mode one is write-only, so it reads zero
  property p_mode_wo;
    rd_en && addr == `ADDR_C_MODE_ONE |=> rdata == 4'h0;
  endproperty
  a_mode_wo: assert property (p_mode_wo)
    else $error("mode one readable");

  // Output mode of the first timer has three bits
  property p_out_c3;
    rd_en && addr == `ADDR_C_OUT_MODE |=> !rdata[3];
  endproperty
  a_out_c3: assert property (p_out_c3)
    else $error("output mode bit 3 set");

  // Flags hold until software writes their word
  property p_irq_c;
    first_timer_irq_flag && !c_irq_wr |=> first_timer_irq_flag;
  endproperty
  a_irq_c: assert property (p_irq_c)
    else $error("first irq flag dropped");

  property p_irq_d;
    second_timer_irq_flag && !d_irq_wr |=> second_timer_irq_flag;
  endproperty
  a_irq_d: assert property (p_irq_d)
    else $error("second irq flag dropped");

  // Reset request is a single pulse tied to an overflow
  property p_wd_once;
    watchdog_reset |=> !watchdog_reset;
  endproperty
  a_wd_once: assert property (p_wd_once)
    else $error("watchdog pulse too long");

  property p_wd_irq;
    watchdog_reset |-> ##[0:1] first_timer_irq_flag;
  endproperty
  a_wd_irq: assert property (p_wd_irq)
    else $error("watchdog without overflow");

  // Outputs low and pins free just after reset
  property p_rst_pins;
    !$past(arst_n) |-> !first_timer_output_pin && !second_timer_output_pin
      && !first_timer_pin_sel && !second_timer_pin_sel;
  endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("pins not idle after reset");

  // Pin selects move only two edges after a mode write
  property p_sel_c;
    $changed(first_timer_pin_sel) |-> $past(c_out_wr, 2);
  endproperty
  a_sel_c: assert property (p_sel_c)
    else $error("first select moved alone");

  property p_sel_d;
    $changed(second_timer_pin_sel) |-> $past(d_out_wr, 2);
  endproperty
  a_sel_d: assert property (p_sel_d)
    else $error("second select moved alone");
endmodule // dual_timers_chk

// ### tb/event_source.sv
// External event source driving the event input pin
`timescale 1ns/1ps

module event_source (
  // Clock
  input  wire  clk,
  // Event pin
  output logic level
);
  // Idle low from time zero
  initial level = 1'b0;

  // Whole pulses; each phase held two cycles at least
  task automatic pulse(input int count, input int width);
    int w;
    w = (width < 2) ? 2 : width;
    repeat (count) begin
      @(posedge clk);
      level <= 1'b1;
      repeat (w) @(posedge clk);
      level <= 1'b0;
      repeat (w - 1) @(posedge clk);
    end
  endtask
endmodule // event_source

// ### tb/test_dual_timers.sv
// Directed bench for the dual timers
`timescale 1ns/1ps
`include "dual_timer_map.vh"

module test_dual_timers;
  logic       clk;
  logic       arst_n;
  logic [5:0] addr;
  logic [3:0] wdata;
  logic       wr_en;
  logic       rd_en;
  wire  [3:0] rdata;
  wire        ev_pin;
  wire        c_pin;
  wire        c_sel;
  wire        d_pin;
  wire        d_sel;
  wire        c_irq;
  wire        d_irq;
  wire        wd_rst;
  int         err_count;
  int         samples_checked;
  int         hi;
  int         fl;
  logic [3:0] v;
  logic [7:0] b;
  logic [7:0] ev_exp [4] = '{8'h00, 8'h03, 8'h03, 8'h06};
  // Tap period per clock source code, from the tap masks
  int         div_len [6] = '{`TAP_1024 + 1, `TAP_512 + 1, `TAP_256 + 1,
                              `TAP_128 + 1, `TAP_32 + 1, `TAP_8 + 1};

  // 100 MHz clock
  always #5 clk = ~clk;

  dual_timers u_dut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .event_trigger_pin(ev_pin), .first_timer_output_pin(c_pin),
    .first_timer_pin_sel(c_sel), .second_timer_output_pin(d_pin),
    .second_timer_pin_sel(d_sel), .first_timer_irq_flag(c_irq),
    .second_timer_irq_flag(d_irq), .watchdog_reset(wd_rst));

  event_source u_src (.clk(clk), .level(ev_pin));

  // Compare and count
  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Async reset held ten cycles
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask

  // Bus write, then an idle cycle so strobes never clash
  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  // Bus read; data taken inside the answer cycle
  task automatic rd(input logic [5:0] a, output logic [3:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  // Byte load low first; byte read high first
  task automatic load(input logic [5:0] lo, input logic [7:0] x);
    wr(lo, x[3:0]);
    wr(lo + 6'h1, x[7:4]);
  endtask

  task automatic cnt(input logic [5:0] lo, output logic [7:0] x);
    rd(lo + 6'h1, x[7:4]);
    rd(lo, x[3:0]);
  endtask

  // Bounded wait for a rise, so the level is known to be fresh:
  // 0 first irq, 1 watchdog, else first pin
  task automatic wait_hi(input int w, input int lim);
    int   n;
    logic s;
    logic armed;
    n = 0;
    armed = 1'b0;
    #1 s = (w == 0) ? c_irq : (w == 1) ? wd_rst : c_pin;
    while (s !== 1'b1 || !armed) begin
      armed = armed || (s === 1'b0);
      n++;
      if (n > lim) begin
        err_count++;
        $display("CHECK FAILED wait %0d expected 1 seen timeout", w);
        stop_test();
      end
      @(posedge clk);
      #1 s = (w == 0) ? c_irq : (w == 1) ? wd_rst : c_pin;
    end
    samples_checked++;
    @(posedge clk);
  endtask

  // High samples and level changes of the first pin
  task automatic watch(input int n);
    logic last;
    hi = 0;
    fl = 0;
    #1 last = c_pin;
    repeat (n) begin
      @(posedge clk);
      #1;
      hi += c_pin;
      fl += (c_pin !== last);
      last = c_pin;
    end
    @(posedge clk);
  endtask

  task automatic t_reset();
    rd(`ADDR_C_OUT_MODE, v);
    check("c_out_mode", v, 8'h00);
    wr(`ADDR_C_OUT_MODE, 4'hf);
    rd(`ADDR_C_OUT_MODE, v);
    check("c_out_width", v, 8'h07);
    wr(`ADDR_C_OUT_MODE, 4'h0);
    rd(`ADDR_C_MODE_ONE, v);
    check("c_mode_one", v, 8'h00);
    check("d_pin", d_pin, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_count();
    wr(`ADDR_C_MODE_ONE, 4'h0);
    repeat (2) @(posedge clk);
    load(`ADDR_C_LOW, 8'hff);
    wait_hi(0, 1100);
    cnt(`ADDR_C_LOW, b);
    check("c_wrap_free", b, 8'h00);
    wr(`ADDR_C_LOW, 4'h5);
    cnt(`ADDR_C_LOW, b);
    check("c_low_only", b, 8'h00);
    wr(`ADDR_C_HIGH, 4'h3);
    rd(`ADDR_C_HIGH, v);
    // Count moves to 79 between the two halves of the read
    load(`ADDR_C_LOW, 8'h79);
    rd(`ADDR_C_LOW, b[3:0]);
    check("c_latch", {v, b[3:0]}, 8'h35);
    wr(`ADDR_C_HIGH, 4'h2);
    cnt(`ADDR_C_LOW, b);
    check("c_high_only", b, 8'h29);
    wr(`ADDR_IRQ_C, 4'h0);
    rd(`ADDR_IRQ_C, v);
    check("c_irq_clear", v, 8'h00);
    wr(`ADDR_C_MODE_ONE, 4'h8);
    repeat (2) @(posedge clk);
    load(`ADDR_C_LOW, 8'hff);
    wait_hi(0, 1100);
    cnt(`ADDR_C_LOW, b);
    check("c_reload", b, 8'hff);
    $display("count test done");
  endtask

  task automatic t_wd();
    wr(`ADDR_WATCHDOG, 4'h2);
    load(`ADDR_C_LOW, 8'hff);
    wait_hi(1, 1100);
    do_reset();
    rd(`ADDR_IRQ_C, v);
    check("c_irq_reset", v, 8'h00);
    check("c_pin_reset", c_pin, 8'h00);
    $display("watchdog test done");
  endtask

  // Any window of two tap periods holds exactly two ticks
  task automatic t_div();
    for (int s = 1; s < 6; s++) begin
      wr(`ADDR_C_MODE_ONE, 4'(s));
      repeat (2) @(posedge clk);
      load(`ADDR_C_LOW, 8'h00);
      repeat (2 * div_len[s] - 1) @(posedge clk);
      cnt(`ADDR_C_LOW, b);
      check("c_divider", b, 8'h02);
    end
    $display("divider test done");
  endtask

  task automatic t_out();
    wr(`ADDR_C_MODE_ONE, 4'hf);
    repeat (2) @(posedge clk);
    load(`ADDR_C_LOW, 8'hfe);
    wr(`ADDR_C_OUT_MODE, 4'h1);
    watch(40);
    check("c_sel", c_sel, 8'h01);
    check("toggle", fl >= 9 && fl <= 11, 8'h01);
    // Force-low is chosen just after a rise, while the pin is high
    wait_hi(2, 12);
    wr(`ADDR_C_OUT_MODE, 4'h2);
    watch(20);
    check("force_low", c_pin, 8'h00);
    wr(`ADDR_C_OUT_MODE, 4'h3);
    watch(20);
    watch(20);
    check("force_high", {c_pin, 7'(fl)}, 8'h80);
    // Period of four ticks, high for one tick
    load(`ADDR_C_LOW, 8'hfc);
    wr(`ADDR_C_OUT_MODE, 4'h4);
    repeat (10) @(posedge clk);
    watch(48);
    check("pwm_duty", hi >= 10 && hi <= 14, 8'h01);
    $display("output test done");
  endtask

  task automatic t_event();
    wr(`ADDR_D_MODE_ONE, 4'h7);
    wr(`ADDR_PORT_SEL_C, 4'h1);
    for (int e = 0; e < 4; e++) begin
      wr(`ADDR_EDGE_SEL, 4'(e));
      load(`ADDR_D_LOW, 8'h00);
      u_src.pulse(3, 3);
      cnt(`ADDR_D_LOW, b);
      check("event_count", b, ev_exp[e]);
    end
    wr(`ADDR_D_OUT_MODE, 4'h1);
    load(`ADDR_D_LOW, 8'hfe);
    u_src.pulse(1, 3);
    cnt(`ADDR_D_LOW, b);
    check("d_wrap", b, 8'h00);
    check("d_wrap_irq", d_irq, 8'h01);
    check("d_toggle", d_pin, 8'h01);
    $display("event test done");
  endtask

  task automatic t_cap();
    wr(`ADDR_D_MODE_ONE, 4'h6);
    wr(`ADDR_EDGE_SEL, 4'h2);
    load(`ADDR_D_LOW, 8'h80);
    wr(`ADDR_D_OUT_MODE, 4'h1);
    wr(`ADDR_IRQ_D, 4'h0);
    check("d_sel_on", d_sel, 8'h01);
    wr(`ADDR_D_OUT_MODE, 4'h8);
    repeat (200) @(posedge clk);
    check("d_sel_off", d_sel, 8'h00);
    u_src.pulse(1, 3);
    rd(`ADDR_D_LOW, b[3:0]);
    rd(`ADDR_D_HIGH, b[7:4]);
    // About 203 cycles at one tick per four, counted from zero
    check("capture_byte", b >= 8'h30 && b <= 8'h35, 8'h01);
    check("d_irq_capture", d_irq, 8'h01);
    rd(`ADDR_CAPTURE, v);
    check("capture_flags", v, 8'h01);
    u_src.pulse(1, 3);
    rd(`ADDR_CAPTURE, v);
    check("capture_error", v, 8'h03);
    wr(`ADDR_CAPTURE, 4'h0);
    rd(`ADDR_CAPTURE, v);
    check("capture_clear", v, 8'h00);
    // Falling only: status alone; both edges: status and error
    for (int e = 1; e < 4; e += 2) begin
      wr(`ADDR_EDGE_SEL, 4'(e));
      u_src.pulse(1, 3);
      rd(`ADDR_CAPTURE, v);
      check("capture_edges", v, 8'(e));
      wr(`ADDR_CAPTURE, 4'h0);
    end
    $display("capture test done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    clk = 1'b0;
    addr = 6'h00;
    wdata = 4'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    err_count = 0;
    samples_checked = 0;
    do_reset();
    t_reset();
    t_count();
    t_wd();
    t_div();
    t_out();
    t_event();
    t_cap();
    stop_test();
  end
endmodule // test_dual_timers

bind dual_timers dual_timers_chk u_chk (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata),
  .first_timer_output_pin(first_timer_output_pin),
  .first_timer_pin_sel(first_timer_pin_sel),
  .second_timer_output_pin(second_timer_output_pin),
  .second_timer_pin_sel(second_timer_pin_sel),
  .first_timer_irq_flag(first_timer_irq_flag),
  .second_timer_irq_flag(second_timer_irq_flag),
  .watchdog_reset(watchdog_reset));
